//--- lpm_params.svh
/*
 * constants of the mode register set: addresses, field positions, codes, timing
 * assumes it is included by lpm_pkg.sv and by the design modules, once each
 */
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH

// ************************************************************
// mode register addresses
// ************************************************************
`define LPM_ADDR_LATENCY 8'h02
`define LPM_ADDR_DRIVE 8'h03
`define LPM_ADDR_TEMP 8'h04
`define LPM_ADDR_MAKER 8'h05
`define LPM_ADDR_REV1 8'h06
`define LPM_ADDR_REV2 8'h07
`define LPM_ADDR_GEOM 8'h08
`define LPM_ADDR_TEST 8'h09
`define LPM_ADDR_CALIB 8'h0A

// ************************************************************
// field codes
// ************************************************************
`define LPM_RL_MIN_CODE 4'h1
`define LPM_RL_MAX_CODE 4'h6
`define LPM_RL_OFFSET 4'h2
`define LPM_RL_RESET 4'h1
`define LPM_DS_RESET 4'h2
`define LPM_DS_RSVD 4'h5
`define LPM_DS_MIN_CODE 4'h1
`define LPM_DS_MAX_CODE 4'h7
`define LPM_TEMP_TUF_BIT 7
`define LPM_RATE_HOT_BIT 2
`define LPM_RATE_LOW 3'h0
`define LPM_RATE_HIGH 3'h7
`define LPM_RATE_DERATE 3'h6
`define LPM_GEOM_TYPE 2'h0
`define LPM_GEOM_DENSITY 4'h5
`define LPM_GEOM_WIDTH 2'h1
`define LPM_TEST_VALUE 8'h00
`define LPM_READ_ZERO 8'h00
`define LPM_CAL_INIT 8'hFF
`define LPM_CAL_LONG 8'hAB
`define LPM_CAL_SHORT 8'h56
`define LPM_CAL_RESET 8'hC3
`define LPM_STR_NONE 2'h0
`define LPM_STR_TIED 2'h1
`define LPM_STR_PASS 2'h3

// ************************************************************
// forbidden non-wrap start columns
// ************************************************************
`define LPM_COL_PAGE_LO 10'h3FE
`define LPM_COL_SUB_LO 10'h1FE
`define LPM_COL_SPAN 10'h004

// ************************************************************
// timing: times in ns, counts rounded up to whole cycles
// ************************************************************
`define LPM_CLK_NS 50
`define LPM_CAL_INIT_NS 1000
`define LPM_CAL_LONG_NS 360
`define LPM_CAL_SHORT_NS 90
`define LPM_CAL_RESET_NS 50
// edges after reset before the synchroniser shows a real pin level
`define LPM_SYNC_SETTLE 3'h4
`define LPM_CYC(ns) (((ns) + `LPM_CLK_NS - 1) / `LPM_CLK_NS)

`endif

//--- lpm_pkg.sv
/*
 * types shared by the mode register set modules
 * assumes lpm_params.svh sits in the same folder
 */
`include "lpm_params.svh"

package lpm_pkg;
   typedef enum logic [1:0] {
      LPM_CAL_IDLE = 2'b00,
      LPM_CAL_RUN = 2'b01,
      LPM_CAL_DONE = 2'b11
   } lpm_cal_state_t;

   typedef enum logic [1:0] {
      LPM_KIND_INIT = 2'b00,
      LPM_KIND_LONG = 2'b01,
      LPM_KIND_SHORT = 2'b10,
      LPM_KIND_RESET = 2'b11
   } lpm_cal_kind_t;
endpackage

//--- lpm_sync.sv
/*
 * three-stage synchroniser for pin-level inputs; output follows once stages 2 and 3 agree
 * assumes inputs are quasi-static levels from outside the clk_sys domain
 */
`timescale 1ns/1ps

module lpm_sync import lpm_pkg::*; #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // pin levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } lpm_sync_state_t;

   lpm_sync_state_t st_reg;
   lpm_sync_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // per bit: only a value seen twice in a row is passed on
      for (int i = 0; i < WIDTH; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.q[i] = st_reg.s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_out = st_reg.q;
endmodule

//--- lpm_mode_regs.sv
/*
 * mode registers 02h..0Ah of a low-power DDR2 SDRAM: latency, drive, temperature,
 * identification and calibration command, reached by mode register read/write strobes
 * assumes the command decoder delivers one-cycle strobes on clk_sys and that the
 * temperature sensor code and calibration pin strap arrive as asynchronous levels
 */
`timescale 1ns/1ps
`include "lpm_params.svh"

// Operation
// (RULE1) controller avoids non-wrap BL4 starts crossing page or sub-page boundary
// (RULE2) latency register bits 3:0 select read latency 3..8 by codes 1..6
// (RULE3) write latency follows read latency: 1,2,2,3,4,4
// (RULE4) drive register bits 3:0 select output impedance; code 0101b reserved
// (RULE5) temperature register bits 2:0 report required refresh interval code
// (RULE6) update flag bit 7 sets when refresh code changed since last read
// (RULE7) reading the temperature register clears the update flag
// (RULE8) update flag is zero at power-up; refresh code undefined until updated
// (RULE9) refresh code bit 2 set means device hotter than 85 degrees
// (RULE10) controller treats refresh codes 000b and 111b as out of range
// (RULE11) controller derates core row timings by 1.875 ns when indicated
// (RULE12) register 05h returns eight-bit maker identification
// (RULE13) register 06h returns first revision identifier
// (RULE14) register 07h returns second revision identifier
// (RULE15) register 08h reports type, density 2 gigabit and x16 width
// (RULE16) register 09h is reserved for vendor test mode
// (RULE17) calibration register codes start init, long, short or reset calibration
// (RULE18) reserved calibration codes are ignored
// (RULE19) controller never writes reserved calibration codes
// (RULE20) calibration pin tied to supply: default calibration, commands ignored
// (RULE21) pin to ground via reference resistor: all calibration commands work
// (RULE22) self-test report updates when initialization calibration completes
module lpm_mode_regs import lpm_pkg::*; #(
   parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] REV_ID_ONE = 8'h01, // arbitrary value
   parameter logic [7:0] REV_ID_TWO = 8'h02 // arbitrary value
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // mode register write
   input wire logic mrw_valid,
   input wire logic [7:0] mrw_addr,
   input wire logic [7:0] mrw_data,
   // mode register read
   input wire logic mrr_valid,
   input wire logic [7:0] mrr_addr,
   output logic [7:0] mrr_data,
   output logic mrr_done,
   // burst start check
   input wire logic burst_check,
   input wire logic burst_nowrap_bl4,
   input wire logic [9:0] burst_col,
   output logic burst_violation,
   // pins
   input wire logic [2:0] temp_sensor_code,
   input wire logic calib_pin_tied_supply,
   // configuration towards the core
   output logic [3:0] read_latency,
   output logic [2:0] write_latency,
   output logic [3:0] drive_strength,
   output logic temp_above_85,
   output logic rate_out_of_range,
   output logic derate_timing,
   // calibration engine
   output logic calib_busy,
   output logic [1:0] calib_kind,
   output logic calib_done,
   output logic [1:0] resistor_selftest_report
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [3:0] rl_code;
      logic [3:0] read_latency;
      logic [2:0] write_latency;
      logic [3:0] ds_code;
      logic [2:0] rate;
      logic rate_valid;
      logic temp_update_flag;
      logic hot;
      logic oor;
      logic derate;
      logic [7:0] mrr_data;
      logic mrr_done;
      logic viol;
      lpm_cal_state_t cal_state;
      lpm_cal_kind_t cal_kind;
      logic [5:0] cal_cnt;
      logic cal_busy;
      logic cal_done;
      logic [1:0] selftest;
      logic [2:0] settle;
   } lpm_state_t;

   lpm_state_t st_reg;
   lpm_state_t st_next;

   logic [3:0] pins_q;
   logic [2:0] sensor_code;
   logic pin_tied;

   lpm_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .pin_in({calib_pin_tied_supply, temp_sensor_code}),
      .level_out(pins_q)
   );

   assign sensor_code = pins_q[2:0];
   assign pin_tied = pins_q[3];

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [2:0] wl_of(input logic [3:0] rl_code);
      case (rl_code)
         4'h1: wl_of = 3'h1;
         4'h2, 4'h3: wl_of = 3'h2;
         4'h4: wl_of = 3'h3;
         default: wl_of = 3'h4;
      endcase
   endfunction

   // true when col falls in the four forbidden starts beginning at lo
   function automatic logic in_window(input logic [9:0] col, input logic [9:0] lo);
      logic [9:0] d;
      d = col - lo;
      in_window = (d < `LPM_COL_SPAN);
   endfunction

   function automatic logic [5:0] cal_cycles(input lpm_cal_kind_t k);
      case (k)
         LPM_KIND_INIT: cal_cycles = 6'(`LPM_CYC(`LPM_CAL_INIT_NS));
         LPM_KIND_LONG: cal_cycles = 6'(`LPM_CYC(`LPM_CAL_LONG_NS));
         LPM_KIND_SHORT: cal_cycles = 6'(`LPM_CYC(`LPM_CAL_SHORT_NS));
         default: cal_cycles = 6'(`LPM_CYC(`LPM_CAL_RESET_NS));
      endcase
   endfunction

   logic wr_lat;
   logic wr_drv;
   logic wr_cal;
   logic rd_temp;
   logic cal_code_ok;
   lpm_cal_kind_t cal_code_kind;

   assign wr_lat = mrw_valid && (mrw_addr == `LPM_ADDR_LATENCY);
   assign wr_drv = mrw_valid && (mrw_addr == `LPM_ADDR_DRIVE);
   assign wr_cal = mrw_valid && (mrw_addr == `LPM_ADDR_CALIB);
   assign rd_temp = mrr_valid && (mrr_addr == `LPM_ADDR_TEMP);

   always_comb begin
      cal_code_ok = 1'b1;
      cal_code_kind = LPM_KIND_RESET;
      case (mrw_data) // [RULE17]
         `LPM_CAL_INIT: cal_code_kind = LPM_KIND_INIT;
         `LPM_CAL_LONG: cal_code_kind = LPM_KIND_LONG;
         `LPM_CAL_SHORT: cal_code_kind = LPM_KIND_SHORT;
         `LPM_CAL_RESET: cal_code_kind = LPM_KIND_RESET;
         default: cal_code_ok = 1'b0; // [RULE18]
      endcase
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_next = st_reg;
      st_next.mrr_done = 1'b0;
      st_next.viol = 1'b0;
      st_next.cal_done = 1'b0;

      // reserved latency codes leave the setting untouched
      if (wr_lat && mrw_data[3:0] >= `LPM_RL_MIN_CODE
          && mrw_data[3:0] <= `LPM_RL_MAX_CODE) begin // [RULE2]
         st_next.rl_code = mrw_data[3:0];
         st_next.read_latency = 4'(mrw_data[3:0] + `LPM_RL_OFFSET);
         st_next.write_latency = wl_of(mrw_data[3:0]); // [RULE3]
      end

      if (wr_drv && mrw_data[3:0] != `LPM_DS_RSVD && mrw_data[3:0] >= `LPM_DS_MIN_CODE
          && mrw_data[3:0] <= `LPM_DS_MAX_CODE) begin // [RULE4]
         st_next.ds_code = mrw_data[3:0];
      end

      // synchroniser output is its reset value at first; loading that would fake a change
      if (st_reg.settle != `LPM_SYNC_SETTLE) begin
         st_next.settle = st_reg.settle + 3'h1;
      end
      // refresh code tracks the sensor; first load is not a change
      if (st_reg.settle == `LPM_SYNC_SETTLE
          && (sensor_code != st_reg.rate || !st_reg.rate_valid)) begin // [RULE5]
         st_next.rate = sensor_code;
         st_next.rate_valid = 1'b1;
      end
      st_next.hot = st_next.rate[`LPM_RATE_HOT_BIT]; // [RULE9]
      st_next.oor = (st_next.rate == `LPM_RATE_LOW) || (st_next.rate == `LPM_RATE_HIGH);
      st_next.derate = (st_next.rate == `LPM_RATE_DERATE);

      // a change in the same cycle as the read wins over the clear
      if (rd_temp) begin
         st_next.temp_update_flag = 1'b0; // [RULE7]
      end
      if (st_reg.rate_valid && sensor_code != st_reg.rate) begin
         st_next.temp_update_flag = 1'b1; // [RULE6]
      end

      if (mrr_valid) begin
         st_next.mrr_done = 1'b1;
         case (mrr_addr)
            `LPM_ADDR_TEMP: st_next.mrr_data = {st_reg.temp_update_flag, 4'h0, st_reg.rate};
            `LPM_ADDR_MAKER: st_next.mrr_data = MAKER_ID; // [RULE12]
            `LPM_ADDR_REV1: st_next.mrr_data = REV_ID_ONE; // [RULE13]
            `LPM_ADDR_REV2: st_next.mrr_data = REV_ID_TWO; // [RULE14]
            `LPM_ADDR_GEOM: st_next.mrr_data = {`LPM_GEOM_WIDTH, `LPM_GEOM_DENSITY,
               `LPM_GEOM_TYPE}; // [RULE15]
            `LPM_ADDR_TEST: st_next.mrr_data = `LPM_TEST_VALUE; // [RULE16]
            default: st_next.mrr_data = `LPM_READ_ZERO;
         endcase
      end

      // flags a controller start that the boundary table forbids
      if (burst_check && burst_nowrap_bl4) begin
         st_next.viol = in_window(burst_col, `LPM_COL_PAGE_LO)
            || in_window(burst_col, `LPM_COL_SUB_LO); // [RULE1]
      end

      unique case (st_reg.cal_state)
         LPM_CAL_IDLE: begin
            if (wr_cal && cal_code_ok && pin_tied) begin
               // default calibration only; an init command reports the strap as tied
               if (cal_code_kind == LPM_KIND_INIT) begin
                  st_next.selftest = `LPM_STR_TIED; // [RULE20]
               end
            end else if (wr_cal && cal_code_ok) begin // [RULE21]
               st_next.cal_state = LPM_CAL_RUN;
               st_next.cal_kind = cal_code_kind;
               st_next.cal_cnt = cal_cycles(cal_code_kind) - 6'h01;
               st_next.cal_busy = 1'b1;
            end
         end
         LPM_CAL_RUN: begin
            // commands arriving while busy are dropped
            if (st_reg.cal_cnt == 6'h00) begin
               st_next.cal_state = LPM_CAL_DONE;
               st_next.cal_busy = 1'b0;
               st_next.cal_done = 1'b1;
               if (st_reg.cal_kind == LPM_KIND_INIT) begin
                  st_next.selftest = `LPM_STR_PASS; // [RULE22]
               end
            end else begin
               st_next.cal_cnt = st_reg.cal_cnt - 6'h01;
            end
         end
         LPM_CAL_DONE: begin
            st_next.cal_state = LPM_CAL_IDLE;
         end
         default: begin
            st_next.cal_state = LPM_CAL_IDLE;
            st_next.cal_busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_reg <= '0;
         st_reg.rl_code <= `LPM_RL_RESET;
         st_reg.read_latency <= `LPM_RL_RESET + `LPM_RL_OFFSET;
         st_reg.write_latency <= 3'h1;
         st_reg.ds_code <= `LPM_DS_RESET;
         st_reg.temp_update_flag <= 1'b0; // [RULE8]
         st_reg.cal_state <= LPM_CAL_IDLE;
         st_reg.selftest <= `LPM_STR_NONE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign mrr_data = st_reg.mrr_data;
   assign mrr_done = st_reg.mrr_done;
   assign burst_violation = st_reg.viol;
   assign read_latency = st_reg.read_latency;
   assign write_latency = st_reg.write_latency;
   assign drive_strength = st_reg.ds_code;
   assign temp_above_85 = st_reg.hot;
   assign rate_out_of_range = st_reg.oor; // [RULE10]
   assign derate_timing = st_reg.derate; // [RULE11]
   assign calib_busy = st_reg.cal_busy;
   assign calib_kind = st_reg.cal_kind;
   assign calib_done = st_reg.cal_done;
   assign resistor_selftest_report = st_reg.selftest;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   tuf_set_a: assert property ( // [RULE6]
      st_reg.rate_valid && sensor_code != st_reg.rate |=> st_reg.temp_update_flag)
      else $error("update flag not set after refresh code change");

   tuf_clear_a: assert property ( // [RULE7]
      rd_temp && !(st_reg.rate_valid && sensor_code != st_reg.rate) |=> !st_reg.temp_update_flag)
      else $error("update flag not cleared by read");

   tuf_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0) // [RULE8]
      srst |=> !st_reg.temp_update_flag)
      else $error("update flag not zero after reset");

   wl_pair_a: assert property ( // [RULE3]
      write_latency == wl_of(read_latency - `LPM_RL_OFFSET))
      else $error("write latency does not match read latency");

   rl_write_a: assert property ( // [RULE2]
      wr_lat && mrw_data[3:0] == 4'h6 |=> read_latency == 4'h8 ##1 $stable(read_latency)
      || $past(mrw_valid))
      else $error("read latency code not applied");

   ds_rsvd_a: assert property ( // [RULE4]
      wr_drv && mrw_data[3:0] == `LPM_DS_RSVD |=> $stable(drive_strength))
      else $error("reserved drive code changed setting");

   hot_bit_a: assert property ( // [RULE9]
      st_reg.rate_valid |=> temp_above_85 == $past(sensor_code[`LPM_RATE_HOT_BIT]))
      else $error("hot flag disagrees with refresh code");

   maker_read_a: assert property ( // [RULE12]
      mrr_valid && mrr_addr == `LPM_ADDR_MAKER |=> mrr_done && mrr_data == MAKER_ID)
      else $error("maker id read wrong");

   geom_read_a: assert property ( // [RULE15]
      mrr_valid && mrr_addr == `LPM_ADDR_GEOM |=> mrr_data == 8'h54)
      else $error("geometry read wrong");

   cal_rsvd_a: assert property ( // [RULE18]
      st_reg.cal_state == LPM_CAL_IDLE && wr_cal && !cal_code_ok |=> !calib_busy)
      else $error("reserved calibration code started calibration");

   cal_tied_a: assert property ( // [RULE20]
      st_reg.cal_state == LPM_CAL_IDLE && wr_cal && pin_tied |=> !calib_busy)
      else $error("calibration ran with pin tied to supply");

   cal_short_a: assert property ( // [RULE21]
      st_reg.cal_state == LPM_CAL_IDLE && wr_cal && !pin_tied
      && mrw_data == `LPM_CAL_SHORT |=> calib_busy [*2] ##1 (!calib_busy && calib_done))
      else $error("short calibration length wrong");

   selftest_a: assert property ( // [RULE22]
      calib_done && calib_kind == LPM_KIND_INIT |-> resistor_selftest_report == `LPM_STR_PASS)
      else $error("self-test report not updated");

   tuf_cov_c: cover property (rd_temp && st_reg.temp_update_flag);
   cal_init_c: cover property (calib_done && calib_kind == LPM_KIND_INIT);
   viol_c: cover property (burst_violation);
   rl_c: cover property (wr_lat ##1 read_latency == 4'h8);
endmodule

//--- lpm_ctl_model.sv
/*
 * controller side model: issues mode register writes, reads and burst start probes
 * assumes the block answers a read or a probe exactly one edge after taking it
 */
`timescale 1ns/1ps

module lpm_ctl_model (
   // clock
   input wire logic clk_sys,
   // requests towards the register block
   output logic mrw_valid,
   output logic [7:0] mrw_addr,
   output logic [7:0] mrw_data,
   output logic mrr_valid,
   output logic [7:0] mrr_addr,
   output logic burst_check,
   output logic burst_nowrap_bl4,
   output logic [9:0] burst_col,
   // answers
   input wire logic [7:0] mrr_data,
   input wire logic mrr_done,
   input wire logic burst_violation
);
   // ****************
   // idle levels
   // ****************
   initial begin
      {mrw_valid, mrr_valid, burst_check, burst_nowrap_bl4} = 4'h0;
      {mrw_addr, mrw_data, mrr_addr} = 24'h0;
      burst_col = 10'h0;
   end

   // ****************
   // requests
   // ****************
   // released lines show the inverse so a stale value is never read as valid
   // codes pass through as given: only a refusal scenario hands in a reserved one
   task automatic mr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      mrw_valid = 1'b1;
      mrw_addr = a;
      mrw_data = d;
      @(posedge clk_sys);
      #1;
      mrw_valid = 1'b0;
      mrw_addr = ~a;
      mrw_data = ~d;
   endtask

   task automatic mr_read(input logic [7:0] a, output logic [7:0] d, output logic dn);
      @(posedge clk_sys);
      #1;
      mrr_valid = 1'b1;
      mrr_addr = a;
      @(posedge clk_sys);
      #1;
      mrr_valid = 1'b0;
      mrr_addr = ~a;
      d = mrr_data;
      dn = mrr_done;
   endtask

   // a forbidden start column is sent as a non-wrap start to see it flagged, or as a wrapping start to see it pass
   task automatic burst_probe(input logic [9:0] col, input logic nw, output logic viol);
      @(posedge clk_sys);
      #1;
      burst_check = 1'b1;
      burst_nowrap_bl4 = nw;
      burst_col = col;
      @(posedge clk_sys);
      #1;
      burst_check = 1'b0;
      burst_nowrap_bl4 = ~nw;
      burst_col = ~col;
      viol = burst_violation;
   endtask
endmodule

//--- tb.sv
/*
 * testbench of the mode register block: settings, temperature flag, ids, calibration, bursts
 * assumes lpm_ctl_model and the design files are compiled before it
 */
`timescale 1ns/1ps

`define TB_CHK(act, exp) \
   begin \
      checks++; \
      if ((act) !== (exp)) begin \
         error_cnt++; \
         $display("BAD t=%0t got=%h exp=%h", $time, (act), (exp)); \
      end \
   end

module tb;
   // arbitrary identification codes, chosen to differ from the defaults
   localparam logic [7:0] MAKER = 8'h3C;
   localparam logic [7:0] REV1 = 8'h11;
   localparam logic [7:0] REV2 = 8'h22;

   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [2:0] temp_sensor_code = 3'h3;
   logic calib_pin_tied_supply = 1'b0;
   logic mrw_valid, mrr_valid, burst_check, burst_nowrap_bl4, mrr_done, burst_violation;
   logic [7:0] mrw_addr, mrw_data, mrr_addr, mrr_data;
   logic [9:0] burst_col;
   logic [3:0] read_latency, drive_strength;
   logic [2:0] write_latency;
   logic temp_above_85, rate_out_of_range, derate_timing, calib_busy, calib_done;
   logic [1:0] calib_kind, resistor_selftest_report;
   int error_cnt = 0;
   int checks = 0;
   logic [3:0] rl = 4'h3;
   logic [2:0] wl = 3'h1;
   logic [3:0] ds = 4'h2;
   logic v;
   logic [2:0] wl_tab [0:6] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4};
   logic [2:0] rates [0:5] = '{3'h1, 3'h2, 3'h6, 3'h5, 3'h7, 3'h0};
   logic [7:0] ida [0:8] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h02, 8'h03, 8'h0A, 8'h20};
   logic [7:0] ide [0:8] = '{MAKER, REV1, REV2, 8'h54, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [9:0] cols [0:11] = '{10'h3FE, 10'h3FF, 10'h000, 10'h001, 10'h1FE, 10'h1FF,
      10'h200, 10'h201, 10'h3FC, 10'h002, 10'h1FD, 10'h202};

   always #25 clk_sys = ~clk_sys;

   lpm_mode_regs #(.MAKER_ID(MAKER), .REV_ID_ONE(REV1), .REV_ID_TWO(REV2)) i_dut (
      .clk_sys, .srst, .mrw_valid, .mrw_addr, .mrw_data, .mrr_valid, .mrr_addr, .mrr_data,
      .mrr_done, .burst_check, .burst_nowrap_bl4, .burst_col, .burst_violation,
      .temp_sensor_code, .calib_pin_tied_supply, .read_latency, .write_latency,
      .drive_strength, .temp_above_85, .rate_out_of_range, .derate_timing, .calib_busy,
      .calib_kind, .calib_done, .resistor_selftest_report
   );

   lpm_ctl_model i_ctl (
      .clk_sys, .mrw_valid, .mrw_addr, .mrw_data, .mrr_valid, .mrr_addr, .burst_check,
      .burst_nowrap_bl4, .burst_col, .mrr_data, .mrr_done, .burst_violation
   );

   // ****************
   // tasks
   // ****************
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic dn;
      i_ctl.mr_read(a, d, dn);
      `TB_CHK(dn, 1'b1)
      `TB_CHK(d, e)
   endtask

   // counts busy cycles under a bound so a stuck engine cannot hang the run
   task automatic cal_run(input logic [7:0] code, input logic [1:0] kind, input int n);
      int k;
      i_ctl.mr_write(8'h0A, code);
      k = 0;
      `TB_CHK(calib_busy, 1'b1)
      `TB_CHK(calib_kind, kind)
      while (calib_busy === 1'b1 && k < 100) begin
         tick(1);
         k++;
      end
      `TB_CHK(calib_done, 1'b1)
      `TB_CHK(k, n)
   endtask

   task automatic end_of_test();
      if (error_cnt == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ****************
   // tests
   // ****************
   initial begin
      tick(8);
      srst = 1'b0;
      `TB_CHK(read_latency, 4'h3)
      `TB_CHK(write_latency, 3'h1)
      `TB_CHK(drive_strength, 4'h2)
      `TB_CHK(resistor_selftest_report, 2'h0)
      tick(10);
      rd_chk(8'h04, 8'h03);
      // upper nibble carries junk that must be ignored
      for (int c = 0; c < 16; c++) begin
         i_ctl.mr_write(8'h02, {4'hA, 4'(c)});
         if (c >= 1 && c <= 6) begin
            rl = 4'(c + 2);
            wl = wl_tab[c];
         end
         `TB_CHK(read_latency, rl)
         `TB_CHK(write_latency, wl)
      end
      for (int c = 0; c < 16; c++) begin
         i_ctl.mr_write(8'h03, {4'h5, 4'(c)});
         if (c != 0 && c != 5 && c < 8) ds = 4'(c);
         `TB_CHK(drive_strength, ds)
      end
      foreach (rates[i]) begin
         temp_sensor_code = rates[i];
         tick(8);
         `TB_CHK(temp_above_85, rates[i][2])
         `TB_CHK(rate_out_of_range, rates[i] inside {3'h0, 3'h7})
         `TB_CHK(derate_timing, rates[i] == 3'h6)
         rd_chk(8'h04, {5'h10, rates[i]});
         rd_chk(8'h04, {5'h00, rates[i]});
      end
      foreach (ida[i]) rd_chk(ida[i], ide[i]);
      foreach (cols[i]) begin
         i_ctl.burst_probe(cols[i], 1'b1, v);
         `TB_CHK(v, i < 8)
      end
      i_ctl.burst_probe(10'h3FE, 1'b0, v);
      `TB_CHK(v, 1'b0)
      cal_run(8'hFF, 2'h0, 20);
      `TB_CHK(resistor_selftest_report, 2'h3)
      cal_run(8'hAB, 2'h1, 8);
      cal_run(8'h56, 2'h2, 2);
      cal_run(8'hC3, 2'h3, 1);
      i_ctl.mr_write(8'h0A, 8'h57);
      `TB_CHK(calib_busy, 1'b0)
      i_ctl.mr_write(8'h0A, 8'h00);
      `TB_CHK(calib_busy, 1'b0)
      // a command while busy is dropped and the running one finishes on time
      i_ctl.mr_write(8'h0A, 8'hAB);
      i_ctl.mr_write(8'h0A, 8'h56);
      `TB_CHK(calib_kind, 2'h1)
      tick(6);
      `TB_CHK(calib_done, 1'b1)
      calib_pin_tied_supply = 1'b1;
      tick(8);
      i_ctl.mr_write(8'h0A, 8'hFF);
      tick(1);
      `TB_CHK(calib_busy, 1'b0)
      `TB_CHK(resistor_selftest_report, 2'h1)
      i_ctl.mr_write(8'h0A, 8'hAB);
      `TB_CHK(calib_busy, 1'b0)
      temp_sensor_code = 3'h5;
      srst = 1'b1;
      tick(2);
      srst = 1'b0;
      `TB_CHK(read_latency, 4'h3)
      `TB_CHK(drive_strength, 4'h2)
      tick(10);
      rd_chk(8'h04, 8'h05);
      end_of_test();
   end

   initial begin
      repeat (4000) @(posedge clk_sys);
      error_cnt++;
      end_of_test();
   end
endmodule
